/* design/mprx_pkg.sv */
// Package for the pointing device report receiver: constants, types and helpers
package mprx_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 50;
    localparam int TIMEOUT_US = 2000;
    localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
    localparam int LINK_PERIOD_LONGEST_US = 50;

    // ****************************************
    // Register bus and map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_REPORT = 8'h0C;
    localparam logic [7:0] OFF_STATE = 8'h10;

    // Status and mask bit positions
    localparam int ST_REPORT = 0;
    localparam int ST_OVF = 1;
    localparam int ST_PARITY = 2;
    localparam int ST_STOP = 3;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_W = 5;

    // Reset values
    localparam logic CTRL_EN_RESET = 1'h1;
    localparam logic [ST_W-1:0] MASK_RESET = 5'h00;
    localparam logic [ST_W-1:0] STATUS_RESET = 5'h00;

    // ****************************************
    // Frame and report layout
    // ****************************************
    localparam int PAYLOAD_BITS = 8;
    localparam logic [2:0] LAST_PAYLOAD_IDX = 3'h7;
    localparam int B0_LEFT = 0;
    localparam int B0_RIGHT = 1;
    localparam int B0_ZERO = 2;
    localparam int B0_ONE = 3;
    localparam int B0_HSIGN = 4;
    localparam int B0_VSIGN = 5;
    localparam int B0_HOVF = 6;
    localparam int B0_VOVF = 7;
    localparam logic [1:0] IDX_HEAD = 2'h0;
    localparam logic [1:0] IDX_HORIZ = 2'h1;
    localparam logic [1:0] IDX_VERT = 2'h2;

    typedef enum logic [1:0] {
        FR_IDLE = 2'h0,
        FR_DATA = 2'h1,
        FR_PARITY = 2'h3,
        FR_STOP = 2'h2
    } mprx_frame_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
        logic re;
    } mprx_bus_s;

    typedef struct packed {
        logic left_btn;
        logic right_btn;
        logic horiz_sign;
        logic vert_sign;
        logic horiz_ovf;
        logic vert_ovf;
        logic [7:0] horiz_delta;
        logic [7:0] vert_delta;
        logic [8:0] horiz_move;
        logic [8:0] vert_move;
    } mprx_report_s;

    // True when payload plus parity hold an odd count of ones
    function automatic logic mprx_odd_ok(input logic [7:0] payload, input logic par);
        mprx_odd_ok = ^{payload, par};
    endfunction : mprx_odd_ok

endpackage : mprx_pkg

/* design/mprx_sync.sv */
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module mprx_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Asynchronous in, synchronous out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule : mprx_sync

/* design/mprx_receiver.sv */
// Pointing device serial receiver with report assembly and register port
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module mprx_receiver
    import mprx_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Link pins
    input wire logic i_link_clk,
    input wire logic i_link_data,
    // Register port
    input wire mprx_bus_s i_bus,
    output logic [DATA_W-1:0] o_rdata_q,
    // Report stream and interrupt
    output mprx_report_s o_report_q,
    output logic o_report_valid_q,
    output logic o_irq_q
);

    // ****************************************
    // Link synchronisation and edge detect
    // ****************************************
    logic [1:0] link_s;
    logic clk_s;
    logic data_s;
    logic clk_prev_q;
    logic fall;

    mprx_sync #(.W(2)) u_sync (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_async({i_link_clk, i_link_data}),
        .o_sync(link_s)
    );

    assign clk_s = link_s[1];
    assign data_s = link_s[0];
    assign fall = clk_prev_q & ~clk_s;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            clk_prev_q <= 1'h1;
        end else begin
            clk_prev_q <= clk_s;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    logic en_q;
    logic [ST_W-1:0] mask_q;
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] status_d;
    logic [ST_W-1:0] status_set;
    logic [ST_W-1:0] status_clr;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_status;

    assign wr_ctrl = i_bus.we && (i_bus.addr == OFF_CTRL);
    assign wr_mask = i_bus.we && (i_bus.addr == OFF_MASK);
    assign wr_status = i_bus.we && (i_bus.addr == OFF_STATUS);
    assign status_clr = wr_status ? i_bus.wdata[ST_W-1:0] : '0;
    assign status_d = (status_q & ~status_clr) | status_set;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            en_q <= CTRL_EN_RESET;
            mask_q <= MASK_RESET;
            status_q <= STATUS_RESET;
            o_irq_q <= 1'h0;
        end else begin
            en_q <= wr_ctrl ? i_bus.wdata[0] : en_q;
            mask_q <= wr_mask ? i_bus.wdata[ST_W-1:0] : mask_q;
            status_q <= status_d;
            o_irq_q <= |(status_q & mask_q);
        end
    end

    // ****************************************
    // Frame receiver
    // ****************************************
    mprx_frame_e state_q;
    mprx_frame_e state_d;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic par_bad_q;
    logic byte_done_q;
    logic stop_bad_q;
    logic [7:0] rx_byte_q;
    logic [31:0] idle_cnt_q;
    logic timeout;
    logic busy;

    assign busy = (state_q != FR_IDLE);
    // Far longer than the slowest legal link period
    assign timeout = busy && (idle_cnt_q == 32'(TIMEOUT_CYCLES - 1));

    always_comb begin
        state_d = state_q;
        if (timeout || !en_q) begin
            state_d = FR_IDLE;
        end else if (fall) begin
            case (state_q)
                FR_IDLE: begin
                    if (!data_s) begin
                        state_d = FR_DATA;
                    end
                end
                FR_DATA: begin
                    if (bit_q == LAST_PAYLOAD_IDX) begin
                        state_d = FR_PARITY;
                    end
                end
                FR_PARITY: begin
                    state_d = FR_STOP;
                end
                default: begin
                    state_d = FR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= FR_IDLE;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
            par_bad_q <= 1'h0;
        end else begin
            state_q <= state_d;
            if (fall && state_q == FR_IDLE) begin
                bit_q <= 3'h0;
            end else if (fall && state_q == FR_DATA) begin
                bit_q <= bit_q + 3'h1;
                shift_q <= {data_s, shift_q[7:1]};
            end
            if (fall && state_q == FR_PARITY) begin
                par_bad_q <= ~mprx_odd_ok(shift_q, data_s);
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            byte_done_q <= 1'h0;
            stop_bad_q <= 1'h0;
            rx_byte_q <= 8'h00;
            idle_cnt_q <= 32'h0000_0000;
        end else begin
            byte_done_q <= fall && en_q && !timeout && (state_q == FR_STOP);
            if (fall && state_q == FR_STOP) begin
                stop_bad_q <= ~data_s;
                rx_byte_q <= shift_q;
            end
            idle_cnt_q <= (fall || !busy) ? 32'h0000_0000 : idle_cnt_q + 32'h0000_0001;
        end
    end

    // ****************************************
    // Report assembly
    // ****************************************
    logic [1:0] idx_q;
    logic [1:0] idx_d;
    logic [7:0] head_q;
    logic [7:0] horiz_q;
    logic byte_err;
    logic byte_ok;
    logic report_fire;
    mprx_report_s report_d;

    assign byte_err = par_bad_q | stop_bad_q;
    assign byte_ok = byte_done_q && !byte_err;
    assign report_fire = byte_ok && (idx_q == IDX_VERT);

    always_comb begin
        idx_d = idx_q;
        if (timeout || (byte_done_q && byte_err)) begin
            idx_d = IDX_HEAD;
        end else if (byte_ok) begin
            case (idx_q)
                IDX_HEAD: begin
                    idx_d = rx_byte_q[B0_ONE] ? IDX_HORIZ : IDX_HEAD;
                end
                IDX_HORIZ: begin
                    idx_d = IDX_VERT;
                end
                default: begin
                    idx_d = IDX_HEAD;
                end
            endcase
        end
    end

    // Signed moves: right and up positive, magnitude grows with speed
    assign report_d.left_btn = head_q[B0_LEFT];
    assign report_d.right_btn = head_q[B0_RIGHT];
    assign report_d.horiz_sign = head_q[B0_HSIGN];
    assign report_d.vert_sign = head_q[B0_VSIGN];
    assign report_d.horiz_ovf = head_q[B0_HOVF];
    assign report_d.vert_ovf = head_q[B0_VOVF];
    assign report_d.horiz_delta = horiz_q;
    assign report_d.vert_delta = rx_byte_q;
    assign report_d.horiz_move = {head_q[B0_HSIGN], horiz_q};
    assign report_d.vert_move = {head_q[B0_VSIGN], rx_byte_q};

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            idx_q <= IDX_HEAD;
            head_q <= 8'h00;
            horiz_q <= 8'h00;
            o_report_q <= '0;
            o_report_valid_q <= 1'h0;
        end else begin
            idx_q <= idx_d;
            if (byte_ok && idx_q == IDX_HEAD) begin
                head_q <= rx_byte_q;
            end
            if (byte_ok && idx_q == IDX_HORIZ) begin
                horiz_q <= rx_byte_q;
            end
            if (report_fire) begin
                o_report_q <= report_d;
            end
            o_report_valid_q <= report_fire;
        end
    end

    // ****************************************
    // Events and read port
    // ****************************************
    logic [DATA_W-1:0] rd_mux;

    assign status_set[ST_REPORT] = report_fire;
    assign status_set[ST_OVF] = report_fire && (head_q[B0_HOVF] || head_q[B0_VOVF]);
    assign status_set[ST_PARITY] = byte_done_q && par_bad_q;
    assign status_set[ST_STOP] = byte_done_q && stop_bad_q;
    assign status_set[ST_TIMEOUT] = timeout;

    assign rd_mux = (i_bus.addr == OFF_CTRL) ? {31'h0000_0000, en_q} :
                    (i_bus.addr == OFF_STATUS) ? {27'h000_0000, status_q} :
                    (i_bus.addr == OFF_MASK) ? {27'h000_0000, mask_q} :
                    (i_bus.addr == OFF_REPORT) ? {8'h00, o_report_q.vert_delta, o_report_q.horiz_delta, head_q} :
                    (i_bus.addr == OFF_STATE) ? {27'h000_0000, busy, idx_q, state_q} :
                    32'h0000_0000;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata_q <= 32'h0000_0000;
        end else begin
            o_rdata_q <= i_bus.re ? rd_mux : 32'h0000_0000;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    sequence s_start_seen;
        fall && en_q && !timeout && state_q == FR_IDLE && !data_s;
    endsequence

    sequence s_last_payload;
        fall && en_q && !timeout && state_q == FR_DATA && bit_q == LAST_PAYLOAD_IDX;
    endsequence

    property p_start_low;
        s_start_seen |=> state_q == FR_DATA && bit_q == 3'h0;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not taken");

    property p_lsb_first;
        fall && state_q == FR_DATA |=> shift_q[7] == $past(data_s) && shift_q[6:0] == $past(shift_q[7:1]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("payload shift order wrong");

    property p_eleven_bits;
        s_last_payload |=> state_q == FR_PARITY;
    endproperty
    a_eleven_bits: assert property (p_eleven_bits) else $error("parity slot not reached");

    property p_odd_parity;
        fall && state_q == FR_PARITY |=> par_bad_q == !mprx_odd_ok($past(shift_q), $past(data_s));
    endproperty
    a_odd_parity: assert property (p_odd_parity) else $error("parity check wrong");

    property p_stop_error;
        fall && en_q && !timeout && state_q == FR_STOP && !data_s |=> ##1 status_q[ST_STOP];
    endproperty
    a_stop_error: assert property (p_stop_error) else $error("low stop bit not flagged");

    property p_align;
        byte_ok && idx_q == IDX_HEAD && !rx_byte_q[B0_ONE] && !timeout |=> idx_q == IDX_HEAD;
    endproperty
    a_align: assert property (p_align) else $error("unaligned head byte accepted");

    property p_report_done;
        byte_ok && idx_q == IDX_VERT |=> o_report_valid_q && o_report_q.vert_delta == $past(rx_byte_q)
            && o_report_q.horiz_move == {$past(head_q[B0_HSIGN]), $past(horiz_q)};
    endproperty
    a_report_done: assert property (p_report_done) else $error("report not completed");

    property p_overflow_event;
        o_report_valid_q && (o_report_q.horiz_ovf || o_report_q.vert_ovf) |-> status_q[ST_OVF];
    endproperty
    a_overflow_event: assert property (p_overflow_event) else $error("overflow event missing");

    property p_timeout_drop;
        timeout |=> state_q == FR_IDLE && idx_q == IDX_HEAD ##1 status_q[ST_TIMEOUT];
    endproperty
    a_timeout_drop: assert property (p_timeout_drop) else $error("stalled frame kept");

    property p_irq_level;
        |(status_q & mask_q) |=> o_irq_q;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

endmodule : mprx_receiver

/* bench/mprx_mouse_model.sv */
// Behavioural pointing device that sends serial frames on the link pins
`timescale 1ns/1ps
module mprx_mouse_model #(
    parameter int HALF_NS = 80
) (
    // Link pins
    output logic o_link_clk,
    output logic o_link_data
);

    // ****************************************
    // Idle levels
    // ****************************************
    initial begin
        o_link_clk = 1'b1;
        o_link_data = 1'b1;
    end

    // ****************************************
    // Frame sender, bit order start, payload, parity, stop
    // ****************************************
    task automatic send_frame(input logic [7:0] b, input logic bad_par, input logic bad_stop, input int nbits);
        logic [10:0] bits;
        int i;
        bits = {~bad_stop, (~^b) ^ bad_par, b, 1'b0};
        #3;
        for (i = 0; i < nbits; i++) begin
            o_link_data = bits[i];
            #(HALF_NS);
            o_link_clk = 1'b0;
            #(HALF_NS);
            o_link_clk = 1'b1;
        end
        #(HALF_NS);
        o_link_data = ~bits[nbits-1];
        #(4 * HALF_NS);
    endtask : send_frame

endmodule : mprx_mouse_model

/* bench/mprx_receiver_tb.sv */
// Self-checking testbench for the pointing device report receiver
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module mprx_receiver_tb;
    import mprx_pkg::*;

    localparam int TO_CYC = 200;
    localparam int LIMIT = 40000;

    logic i_clock;
    logic i_resetn;
    mprx_bus_s bus_q;
    logic link_clk;
    logic link_data;
    logic [DATA_W-1:0] o_rdata_q;
    mprx_report_s o_report_q;
    logic o_report_valid_q;
    logic o_irq_q;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int rep_cnt = 0;
    mprx_report_s rep_cap;
    logic [4:0] mask_v = 5'h00;

    mprx_receiver #(.TIMEOUT_CYCLES(TO_CYC)) u_mprx_receiver (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_link_clk(link_clk),
        .i_link_data(link_data),
        .i_bus(bus_q),
        .o_rdata_q(o_rdata_q),
        .o_report_q(o_report_q),
        .o_report_valid_q(o_report_valid_q),
        .o_irq_q(o_irq_q)
    );

    mprx_mouse_model u_mprx_mouse_model (
        .o_link_clk(link_clk),
        .o_link_data(link_data)
    );

    // ****************************************
    // Clock, watchdog and report monitor
    // ****************************************
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    always @(posedge i_clock) begin
        if (o_report_valid_q === 1'b1) begin
            rep_cnt++;
            rep_cap = o_report_q;
        end
    end

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            $display("ERROR t=%0t watchdog expired", $time);
            print_verdict();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        bus_q.addr <= a;
        bus_q.wdata <= d;
        bus_q.we <= 1'b1;
        @(posedge i_clock);
        bus_q.we <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clock);
        bus_q.addr <= a;
        bus_q.re <= 1'b1;
        @(posedge i_clock);
        bus_q.re <= 1'b0;
        #1 d = o_rdata_q;
    endtask : bus_read

    function automatic mprx_report_s exp_rep(input logic [7:0] h, input logic [7:0] x, input logic [7:0] y);
        mprx_report_s r;
        r.left_btn = h[0];
        r.right_btn = h[1];
        r.horiz_sign = h[4];
        r.vert_sign = h[5];
        r.horiz_ovf = h[6];
        r.vert_ovf = h[7];
        r.horiz_delta = x;
        r.vert_delta = y;
        r.horiz_move = {h[4], x};
        r.vert_move = {h[5], y};
        return r;
    endfunction : exp_rep

    task automatic check_clear(input logic [31:0] e);
        logic [31:0] d;
        bus_read(OFF_STATUS, d);
        `CHK(d, e)
        `CHK(o_irq_q, |(e[4:0] & mask_v))
        bus_write(OFF_STATUS, 32'h1F);
        repeat (2) @(posedge i_clock);
        #1 `CHK(o_irq_q, 1'b0)
        bus_read(OFF_STATUS, d);
        `CHK(d, 32'h0)
    endtask : check_clear

    task automatic do_report(input logic [7:0] h, input logic [7:0] x, input logic [7:0] y);
        int n;
        int k;
        logic [31:0] d;
        n = rep_cnt;
        u_mprx_mouse_model.send_frame(h, 1'b0, 1'b0, 11);
        u_mprx_mouse_model.send_frame(x, 1'b0, 1'b0, 11);
        u_mprx_mouse_model.send_frame(y, 1'b0, 1'b0, 11);
        for (k = 0; k < 400 && rep_cnt == n; k++) @(posedge i_clock);
        `CHK(rep_cnt, n + 1)
        `CHK(rep_cap, exp_rep(h, x, y))
        bus_read(OFF_REPORT, d);
        `CHK(d, ({8'h00, y, x, h}))
        check_clear({30'h0, h[6] | h[7], 1'b1});
    endtask : do_report

    task automatic set_mask(input logic [4:0] m);
        logic [31:0] d;
        mask_v = m;
        bus_write(OFF_MASK, {27'h0, m});
        bus_read(OFF_MASK, d);
        `CHK(d, ({27'h0, m}))
    endtask : set_mask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin : main
        logic [31:0] d;
        logic [7:0] h;
        int i;
        i_resetn = 1'b0;
        bus_q = '0;
        void'($urandom(32'h346f));
        repeat (6) @(posedge i_clock);
        #1 `CHK(o_report_q, 40'h0)
        `CHK(({o_rdata_q, o_report_valid_q, o_irq_q}), 34'h0)
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_clock);
        bus_read(OFF_CTRL, d);
        `CHK(d, 32'h1)
        bus_read(OFF_MASK, d);
        `CHK(d, 32'h0)
        bus_write(8'h14, 32'hFFFFFFFF);
        bus_read(8'h14, d);
        `CHK(d, 32'h0)
        bus_read(OFF_STATUS, d);
        `CHK(d, 32'h0)
        bus_read(OFF_STATE, d);
        `CHK(d, 32'h0)
        $display("DONE reset");
        do_report(8'hFB, 8'hFF, 8'h00);
        do_report(8'h08, 8'h00, 8'hFF);
        for (i = 0; i < 6; i++) begin
            h = 8'($urandom);
            h[3] = 1'b1;
            h[2] = 1'b0;
            do_report(h, 8'($urandom), 8'($urandom));
        end
        $display("DONE reports");
        set_mask(5'h1F);
        u_mprx_mouse_model.send_frame(8'h02, 1'b0, 1'b0, 11);
        do_report(8'h19, 8'h05, 8'h80);
        u_mprx_mouse_model.send_frame(8'h28, 1'b0, 1'b0, 11);
        u_mprx_mouse_model.send_frame(8'h33, 1'b1, 1'b0, 11);
        repeat (20) @(posedge i_clock);
        check_clear(32'h4);
        do_report(8'h09, 8'h11, 8'h22);
        u_mprx_mouse_model.send_frame(8'h08, 1'b0, 1'b1, 11);
        repeat (20) @(posedge i_clock);
        check_clear(32'h8);
        do_report(8'h3A, 8'h7F, 8'h01);
        u_mprx_mouse_model.send_frame(8'h08, 1'b0, 1'b0, 5);
        bus_read(OFF_STATE, d);
        `CHK(d, ({27'h0, 1'b1, IDX_HEAD, 2'(FR_DATA)}))
        repeat (TO_CYC + 100) @(posedge i_clock);
        check_clear(32'h10);
        do_report(8'h0A, 8'h44, 8'h55);
        bus_write(OFF_CTRL, 32'h0);
        u_mprx_mouse_model.send_frame(8'h08, 1'b0, 1'b0, 11);
        bus_read(OFF_STATE, d);
        `CHK(d, 32'h0)
        bus_read(OFF_STATUS, d);
        `CHK(d, 32'h0)
        bus_write(OFF_CTRL, 32'h1);
        bus_read(OFF_CTRL, d);
        `CHK(d, 32'h1)
        $display("DONE errors");
        set_mask(5'h01);
        do_report(8'hC9, 8'h10, 8'h20);
        set_mask(5'h02);
        do_report(8'h09, 8'h10, 8'h20);
        $display("DONE irq");
        u_mprx_mouse_model.send_frame(8'h08, 1'b0, 1'b0, 5);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clock);
        #1 `CHK(({o_rdata_q, o_report_valid_q, o_irq_q, o_report_q}), 74'h0)
        i_resetn <= 1'b1;
        mask_v = 5'h00;
        repeat (4) @(posedge i_clock);
        bus_read(OFF_STATE, d);
        `CHK(d, 32'h0)
        bus_read(OFF_MASK, d);
        `CHK(d, 32'h0)
        do_report(8'h2B, 8'h03, 8'h04);
        $display("DONE reset again");
        print_verdict();
    end

endmodule : mprx_receiver_tb
